/* File: tdcsm_pkg.sv */
package tdcsm_pkg;

   // timing
   localparam int CLK_PS = 4000;
   localparam int DEAD_NS_0 = 5;
   localparam int DEAD_NS_1 = 10;
   localparam int DEAD_NS_2 = 15;
   localparam int DEAD_NS_3 = 20;
   localparam logic [2:0] DEAD_CYC_0 = 3'((DEAD_NS_0*1000+CLK_PS-1)/CLK_PS);
   localparam logic [2:0] DEAD_CYC_1 = 3'((DEAD_NS_1*1000+CLK_PS-1)/CLK_PS);
   localparam logic [2:0] DEAD_CYC_2 = 3'((DEAD_NS_2*1000+CLK_PS-1)/CLK_PS);
   localparam logic [2:0] DEAD_CYC_3 = 3'((DEAD_NS_3*1000+CLK_PS-1)/CLK_PS);

   // sizes
   localparam int NCHAN = 32;
   localparam logic [5:0] NCHAN_FULL = 6'h20;
   localparam logic [5:0] NCHAN_VHR = 6'h08;
   localparam logic [31:0] MASK_FULL = 32'hFFFF_FFFF;
   localparam logic [31:0] MASK_VHR = 32'h0000_00FF;

   // register offsets
   localparam logic [3:0] ADDR_SETUP = 4'h0;
   localparam logic [3:0] ADDR_ROLL = 4'h1;
   localparam logic [3:0] ADDR_CTRL = 4'h2;
   localparam logic [3:0] ADDR_STAT = 4'h3;
   localparam logic [3:0] ADDR_ACTIVE = 4'h4;
   localparam logic [3:0] ADDR_COARSE = 4'h5;

   // control bits
   localparam int CTRL_APPLY_BIT = 0;
   localparam int CTRL_RUN_BIT = 1;

   // setup codes
   localparam logic [2:0] DLL_SRC_PLL320 = 3'h3;
   localparam logic [1:0] DLL_MODE_320 = 2'h2;
   localparam logic [2:0] LRES_100PS = 3'h0;
   localparam logic [2:0] LRES_VHR = 3'h7;

   // reset values
   localparam logic [31:0] SETUP_RST = 32'h0001_0269;
   localparam logic [11:0] ROLL_RST = 12'hFFF;

   typedef struct packed
   {
      logic [13:0] rsvd;
      logic        leader;
      logic        keep_token;
      logic        bytewise;
      logic        serial;
      logic        match_en;
      logic [2:0]  lead_res;
      logic [1:0]  dll_mode;
      logic [2:0]  dll_src;
      logic [1:0]  dead;
      logic        pair_en;
      logic        trail_en;
      logic        lead_en;
   } tdcsm_setup_type;

   typedef struct packed
   {
      logic [18:0] rsvd;
      logic        running;
      logic        pending;
      logic        token_held;
      logic        ok32;
      logic        res100;
      logic        dll320;
      logic        pll320;
      logic [5:0]  nchan;
   } tdcsm_status_type;

   typedef struct packed
   {
      logic        trail;
      logic [11:0] coarse;
   } tdcsm_stamp_type;

endpackage: tdcsm_pkg

/* File: tdcsm_hit_chan.sv */
`timescale 1ns/1ns
module tdcsm_hit_chan
(
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_nrst,
   input  wire logic       i_ce,
   // pin and setup
   input  wire logic       i_pin,
   input  wire logic       i_arm,
   input  wire logic       i_rise_en,
   input  wire logic       i_fall_en,
   input  wire logic [2:0] i_dead_cyc,
   // hit event
   output logic            o_hit,
   output logic            o_fall
);

   logic       s1_reg;
   logic       s2_reg;
   logic       s3_reg;
   logic       lvl_reg;
   logic [2:0] dead_reg;
   logic       chg;
   logic       fire;

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         s1_reg <= 1'h0;
         s2_reg <= 1'h0;
         s3_reg <= 1'h0;
         lvl_reg <= 1'h0;
      end
      else if (i_ce)
      begin
         s1_reg <= i_pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg)
            lvl_reg <= s3_reg;
      end
   end

   assign chg = (s2_reg == s3_reg) && (s3_reg != lvl_reg);
   assign fire = i_arm && (dead_reg == 3'h0) && chg &&
                 ((s3_reg && i_rise_en) || (!s3_reg && i_fall_en));
   assign o_hit = fire && i_ce;
   assign o_fall = !s3_reg;

   // blanking after each accepted hit
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         dead_reg <= 3'h0;
      else if (i_ce)
      begin
         if (fire)
            dead_reg <= i_dead_cyc;
         else if (dead_reg != 3'h0)
            dead_reg <= dead_reg - 3'h1;
      end
   end

   sequence s_blank3;
      !o_hit [*3];
   endsequence

   property p_dead;
      @(posedge i_clk) disable iff (!i_nrst)
      o_hit && (i_dead_cyc == 3'h3) |=> s_blank3;
   endproperty

   AST_DEAD_BLANK: assert property (p_dead)
      else $error("hit accepted inside dead time");

endmodule: tdcsm_hit_chan

/* File: tdcsm_top.sv */
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ns
// Contract
// - finest resolution mode leaves only eight channels active.
// - 32 channels give 100ps bins from the 320MHz multiplied clock.
// - every hit is an absolute stamp; no common start or stop.
// - coarse count wraps at programmed value; FFF wraps naturally.
// - without matching each measurement leaves as its own word.
// - token kept until all stored data left over the 32 bit bus.
// - rising edges only when leading 1, trailing 0, pairing 0.
// - dead time code 01 blanks a channel 10 ns after a hit.
// - clock source code 011 selects the 320MHz loop clock.
// - delay-line range code 10 selects 320MHz operation.
// - leading bin code 000 selects 100ps resolution.
// - matching enable 0 passes all stored measurements to read-out.
// - bitwise select 0 uses the parallel port, not the serial link.
// - leader select 0 makes the device a chain follower.
module tdcsm_top
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_ce,
   // register port
   input  wire logic [3:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   // hit pins
   input  wire logic [31:0] i_hit,
   // read-out bus
   input  wire logic        i_token_in,
   output logic             o_token_out,
   output logic             o_valid,
   input  wire logic        i_ack,
   output logic      [31:0] o_data,
   // decoded roles
   output logic             o_leader,
   output logic             o_serial_en,
   output logic             o_match_en
);

   tdcsm_pkg::tdcsm_setup_type  stage_reg;
   tdcsm_pkg::tdcsm_setup_type  act_reg;
   tdcsm_pkg::tdcsm_status_type stat;
   tdcsm_pkg::tdcsm_stamp_type  stamp_reg [tdcsm_pkg::NCHAN];
   tdcsm_pkg::tdcsm_stamp_type  sel_stamp;

   logic [11:0] roll_stage_reg;
   logic [11:0] roll_reg;
   logic [11:0] coarse_reg;
   logic        run_reg;
   logic [31:0] pend_reg;
   logic [31:0] out_reg;
   logic        out_full_reg;
   logic [1:0]  byte_reg;
   logic        sent_reg;
   logic [31:0] rdata_reg;

   logic        apply;
   logic        run_wr;
   logic        vhr;
   logic [31:0] chan_mask;
   logic        rise_en;
   logic        fall_en;
   logic        lead_only;
   logic [2:0]  dead_cyc;
   logic [31:0] hit;
   logic [31:0] fall;
   logic [4:0]  sel;
   logic        take;
   logic        par_act;
   logic        beat_done;
   logic        word_done;
   logic        have_data;
   logic        one_shot;

   function automatic logic [4:0] first_idx(input logic [31:0] v);
      logic [4:0] idx;
      idx = 5'h00;
      for (int i = tdcsm_pkg::NCHAN - 1; i >= 0; i--)
         if (v[i])
            idx = 5'(i);
      return idx;
   endfunction: first_idx

   // register port strobes
   assign apply = i_wr && (i_addr == tdcsm_pkg::ADDR_CTRL) &&
                  i_wdata[tdcsm_pkg::CTRL_APPLY_BIT];
   assign run_wr = i_wr && (i_addr == tdcsm_pkg::ADDR_CTRL);

   // staged setup, applied on command
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         stage_reg <= tdcsm_pkg::SETUP_RST;
         roll_stage_reg <= tdcsm_pkg::ROLL_RST;
      end
      else if (i_ce && i_wr)
      begin
         if (i_addr == tdcsm_pkg::ADDR_SETUP)
            stage_reg <= i_wdata;
         if (i_addr == tdcsm_pkg::ADDR_ROLL)
            roll_stage_reg <= i_wdata[11:0];
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         act_reg <= tdcsm_pkg::SETUP_RST;
         roll_reg <= tdcsm_pkg::ROLL_RST;
      end
      else if (i_ce && apply)
      begin
         act_reg <= stage_reg;
         roll_reg <= roll_stage_reg;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         run_reg <= 1'h0;
      else if (i_ce && run_wr)
         run_reg <= i_wdata[tdcsm_pkg::CTRL_RUN_BIT];
   end

   // setup decode
   assign vhr = act_reg.lead_res == tdcsm_pkg::LRES_VHR;
   assign chan_mask = vhr ? tdcsm_pkg::MASK_VHR
                          : tdcsm_pkg::MASK_FULL;
   assign lead_only = act_reg.lead_en && !act_reg.trail_en && !act_reg.pair_en;
   assign rise_en = act_reg.lead_en || act_reg.pair_en;
   assign fall_en = act_reg.trail_en || act_reg.pair_en;
   assign par_act = !act_reg.serial && !act_reg.match_en;
   assign o_leader = act_reg.leader;
   assign o_serial_en = act_reg.serial;
   assign o_match_en = act_reg.match_en;

   always_comb
   begin
      unique case (act_reg.dead)
         2'h0: dead_cyc = tdcsm_pkg::DEAD_CYC_0;
         2'h1: dead_cyc = tdcsm_pkg::DEAD_CYC_1;
         2'h2: dead_cyc = tdcsm_pkg::DEAD_CYC_2;
         2'h3: dead_cyc = tdcsm_pkg::DEAD_CYC_3;
      endcase
   end

   // per-channel front ends
   genvar g;
   generate
      for (g = 0; g < tdcsm_pkg::NCHAN; g++)
      begin: gen_chan
         tdcsm_hit_chan u_chan
         (
            .i_clk      (i_clk),
            .i_nrst     (i_nrst),
            .i_ce       (i_ce),
            .i_pin      (i_hit[g]),
            .i_arm      (run_reg && chan_mask[g]),
            .i_rise_en  (rise_en),
            .i_fall_en  (fall_en),
            .i_dead_cyc (dead_cyc),
            .o_hit      (hit[g]),
            .o_fall     (fall[g])
         );
      end
   endgenerate

   // coarse count, held at zero while run is off, counting from zero once run is set
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         coarse_reg <= 12'h000;
      else if (i_ce)
      begin
         if (!run_reg)
            coarse_reg <= 12'h000;
         else if (coarse_reg == roll_reg)
            coarse_reg <= 12'h000;
         else
            coarse_reg <= coarse_reg + 12'h001;
      end
   end

   // one stored stamp per channel
   assign sel = first_idx(pend_reg);
   assign sel_stamp = stamp_reg[sel];
   assign take = !out_full_reg && (pend_reg != 32'h0000_0000);

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         pend_reg <= 32'h0000_0000;
      else if (i_ce)
      begin
         for (int i = 0; i < tdcsm_pkg::NCHAN; i++)
         begin
            if (hit[i])
               pend_reg[i] <= 1'h1;
            else if (take && (sel == 5'(i)))
               pend_reg[i] <= 1'h0;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         for (int i = 0; i < tdcsm_pkg::NCHAN; i++)
            stamp_reg[i] <= '0;
      end
      else if (i_ce)
      begin
         for (int i = 0; i < tdcsm_pkg::NCHAN; i++)
            if (hit[i])
               stamp_reg[i] <= {fall[i], coarse_reg};
      end
   end

   // output word stage
   assign beat_done = o_valid && i_ack;
   assign word_done = beat_done &&
                      (!act_reg.bytewise || (byte_reg == 2'h3));
   assign one_shot = !act_reg.keep_token && sent_reg;

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         out_reg <= 32'h0000_0000;
         out_full_reg <= 1'h0;
         byte_reg <= 2'h0;
      end
      else if (i_ce)
      begin
         if (take)
         begin
            out_reg <= {3'h0, sel, sel_stamp.trail, 11'h000,
                        sel_stamp.coarse};
            out_full_reg <= 1'h1;
            byte_reg <= 2'h0;
         end
         else if (word_done)
         begin
            out_full_reg <= 1'h0;
            byte_reg <= 2'h0;
         end
         else if (beat_done)
         begin
            out_reg <= {out_reg[23:0], 8'h00};
            byte_reg <= byte_reg + 2'h1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         sent_reg <= 1'h0;
      else if (i_ce)
      begin
         if (!i_token_in)
            sent_reg <= 1'h0;
         else if (word_done)
            sent_reg <= 1'h1;
      end
   end

   // token and bus handshake
   assign have_data = out_full_reg || (pend_reg != 32'h0000_0000);
   assign o_valid = out_full_reg && i_token_in && par_act &&
                    !one_shot;
   assign o_token_out = i_token_in &&
                        (!par_act || !have_data || one_shot);
   assign o_data = act_reg.bytewise ? {24'h00_0000, out_reg[31:24]}
                                    : out_reg;

   // status view
   always_comb
   begin
      stat = '0;
      stat.nchan = vhr ? tdcsm_pkg::NCHAN_VHR : tdcsm_pkg::NCHAN_FULL;
      stat.pll320 = act_reg.dll_src == tdcsm_pkg::DLL_SRC_PLL320;
      stat.dll320 = act_reg.dll_mode == tdcsm_pkg::DLL_MODE_320;
      stat.res100 = act_reg.lead_res == tdcsm_pkg::LRES_100PS;
      stat.ok32 = stat.pll320 && stat.dll320 && stat.res100;
      stat.token_held = i_token_in && !o_token_out;
      stat.pending = have_data;
      stat.running = run_reg;
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         rdata_reg <= 32'h0000_0000;
      else if (i_ce)
      begin
         if (i_rd)
         begin
            case (i_addr)
               tdcsm_pkg::ADDR_SETUP:  rdata_reg <= stage_reg;
               tdcsm_pkg::ADDR_ROLL:   rdata_reg <= {20'h0, roll_stage_reg};
               tdcsm_pkg::ADDR_CTRL:   rdata_reg <= {30'h0, run_reg, 1'h0};
               tdcsm_pkg::ADDR_STAT:   rdata_reg <= stat;
               tdcsm_pkg::ADDR_ACTIVE: rdata_reg <= act_reg;
               tdcsm_pkg::ADDR_COARSE: rdata_reg <= {20'h0, coarse_reg};
               default:                rdata_reg <= 32'h0000_0000;
            endcase
         end
         else
            rdata_reg <= 32'h0000_0000;
      end
   end

   assign o_rdata = rdata_reg;

   // checks
   AST_VHR_EIGHT: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      vhr |-> (hit[31:8] == 24'h00_0000) &&
              (stat.nchan == tdcsm_pkg::NCHAN_VHR))
      else $error("channel above eight active in finest mode");
   AST_FULL32: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      !vhr |-> stat.nchan == tdcsm_pkg::NCHAN_FULL)
      else $error("full channel set not offered");
   AST_WRAP: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      i_ce && run_reg && (coarse_reg == roll_reg)
      |=> (coarse_reg == 12'h000))
      else $error("coarse count missed roll-over");
   AST_STEP: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      i_ce && run_reg && (coarse_reg != roll_reg) && !run_wr
      |=> (coarse_reg == $past(coarse_reg) + 12'h001))
      else $error("coarse count did not advance");
   AST_WORD: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      i_ce && beat_done && !act_reg.bytewise |=> !out_full_reg)
      else $error("word not released after acknowledge");
   AST_TOKEN_KEEP: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      act_reg.keep_token && par_act && have_data |-> !o_token_out)
      else $error("token passed with data still stored");
   AST_LEAD_ONLY: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      lead_only && run_reg |-> ((hit & fall) == 32'h0000_0000))
      else $error("falling edge captured in leading-only mode");
   AST_NO_PAR: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (act_reg.match_en || act_reg.serial) |-> !o_valid)
      else $error("parallel word offered while port not selected");
   AST_HOLD: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      !apply |=> (act_reg == $past(act_reg)))
      else $error("active setup changed without reload");

endmodule: tdcsm_top

/* File: tdcsm_rdctl.sv */
`timescale 1ns/1ns
module tdcsm_rdctl
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   // bench control
   input  wire logic        i_beam,
   input  wire logic [3:0]  i_stall,
   // device side
   input  wire logic        i_token_back,
   input  wire logic        i_valid,
   input  wire logic [31:0] i_data,
   output logic             o_token,
   output logic             o_ack
);
   logic [31:0] words [$];
   logic [3:0]  wait_reg;

   // token sent per beam pulse, withdrawn once the device hands it back
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         o_token <= 1'h0;
      else if (i_beam)
         o_token <= 1'h1;
      else if (o_token && i_token_back)
         o_token <= 1'h0;
   end

   // word taken where valid meets ack, ack raised after optional stall
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_ack    <= 1'h0;
         wait_reg <= 4'h0;
      end
      else if (o_ack && i_valid)
      begin
         words.push_back(i_data);
         o_ack    <= 1'h0;
         wait_reg <= 4'h0;
      end
      else if (i_valid && wait_reg >= i_stall)
         o_ack <= 1'h1;
      else if (i_valid)
         wait_reg <= wait_reg + 4'h1;
   end
endmodule: tdcsm_rdctl

/* File: tdcsm_top_tb_top.sv */
`timescale 1ns/1ns
module tdcsm_top_tb_top;
   logic        clk;
   logic        nrst = 1'h0;
   logic [3:0]  addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'h0;
   logic        rd = 1'h0;
   logic [31:0] rdata;
   logic [31:0] hit = 32'h0;
   logic        tok_in;
   logic        tok_out;
   logic        valid;
   logic        ack;
   logic [31:0] data;
   logic        leader;
   logic        serial_en;
   logic        match_en;
   logic        beam = 1'h0;
   logic [3:0]  stall = 4'h0;
   logic [31:0] v;
   logic [31:0] w;
   logic [31:0] left = 32'h0;
   int          n_errors = 0;
   int          n_compared = 0;
   int          cycles = 0;
   logic [31:0] cfg_tab [3] = '{32'h0001_1E69, 32'h0001_0009,
                                tdcsm_pkg::SETUP_RST};
   logic [9:0]  st_tab [3] = '{10'h0C8, 10'h120, 10'h3E0};

   tdcsm_top DUT
   (
      .i_clk(clk), .i_nrst(nrst), .i_ce(1'h1), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_hit(hit), .i_token_in(tok_in), .o_token_out(tok_out),
      .o_valid(valid), .i_ack(ack), .o_data(data), .o_leader(leader),
      .o_serial_en(serial_en), .o_match_en(match_en)
   );

   tdcsm_rdctl u_ctl
   (
      .i_clk(clk), .i_nrst(nrst), .i_beam(beam), .i_stall(stall),
      .i_token_back(tok_out), .i_valid(valid), .i_data(data),
      .o_token(tok_in), .o_ack(ack)
   );

   initial
   begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         test_done();
      end
   end

   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask: test_done

   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask: check

   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
   endtask: wreg

   task automatic rreg(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      #1 d = rdata;
   endtask: rreg

   task automatic apply(input logic [31:0] cfg, input logic [31:0] ctl);
      wreg(tdcsm_pkg::ADDR_SETUP, cfg);
      wreg(tdcsm_pkg::ADDR_CTRL, ctl);
   endtask: apply

   task automatic pulse(input int ch, input int len);
      @(posedge clk);
      hit[ch] <= 1'h1;
      repeat (len) @(posedge clk);
      hit[ch] <= 1'h0;
      repeat (8) @(posedge clk);
   endtask: pulse

   // one beam pulse, then collect n beats from the controller
   task automatic drain(input int n, input logic [3:0] s);
      u_ctl.words.delete();
      @(posedge clk);
      stall <= s;
      beam  <= 1'h1;
      @(posedge clk);
      beam <= 1'h0;
      repeat (2) @(posedge clk);
      #1;
      if (s > 4'h0)
         check("token_kept", {31'h0, tok_out}, 32'h0);
      for (int i = 0; i < 300 && u_ctl.words.size() < n; i++)
         @(posedge clk);
      repeat (20) @(posedge clk);
      check("beats", 32'(u_ctl.words.size()), 32'(n));
      rreg(tdcsm_pkg::ADDR_STAT, v);
      if (n > 0)
         check("stored", v & 32'h800, left);
   endtask: drain

   initial
   begin
      repeat (16) @(posedge clk);
      nrst <= 1'h1;
      rreg(tdcsm_pkg::ADDR_ACTIVE, v);
      check("active", v, tdcsm_pkg::SETUP_RST);
      check("roles", {29'h0, leader, serial_en, match_en}, 32'h0);
      wreg(4'hF, 32'hFFFF_FFFF);
      rreg(4'hF, v);
      check("unmapped", v, 32'h0);
      wreg(tdcsm_pkg::ADDR_SETUP, cfg_tab[0]);
      rreg(tdcsm_pkg::ADDR_ACTIVE, v);
      check("staged", v, tdcsm_pkg::SETUP_RST);
      for (int i = 0; i < 3; i++)
      begin
         apply(cfg_tab[i], 32'h1);
         rreg(tdcsm_pkg::ADDR_STAT, v);
         check("status", v & 32'h3FF,
               {22'h0, st_tab[i]});
      end
      // finest mode: channel 9 silent, channel 3 kept
      apply(cfg_tab[0], 32'h3);
      pulse(9, 6);
      pulse(3, 6);
      drain(1, 4'h5);
      check("fine_chan", u_ctl.words[0] & 32'h1F80_0000, 32'h0300_0000);
      // two stamps seven cycles apart, leading edges only
      apply(tdcsm_pkg::SETUP_RST, 32'h3);
      @(posedge clk);
      hit[1] <= 1'h1;
      repeat (7) @(posedge clk);
      hit[2] <= 1'h1;
      repeat (10) @(posedge clk);
      hit <= 32'h0;
      repeat (8) @(posedge clk);
      drain(2, 4'h0);
      w = u_ctl.words[1] - u_ctl.words[0];
      check("first", u_ctl.words[0] & 32'h1F80_0000, 32'h0100_0000);
      check("delta", w & 32'hFFF, 32'h7);
      // both edges on: short pulse loses its fall to blanking
      apply(32'h0001_026B, 32'h3);
      pulse(6, 2);
      drain(1, 4'h0);
      pulse(6, 6);
      drain(2, 4'h5);
      check("fall", u_ctl.words[1] & 32'h1F80_0000, 32'h0680_0000);
      // leader, serial and matching: nothing offered, data kept
      apply(32'h0003_6269, 32'h3);
      #1;
      check("roles", {29'h0, leader, serial_en, match_en},
            32'h7);
      pulse(4, 6);
      drain(0, 4'h0);
      apply(tdcsm_pkg::SETUP_RST, 32'h3);
      drain(1, 4'h0);
      // byte-wise beats, most significant first
      apply(32'h0001_8269, 32'h3);
      pulse(5, 6);
      drain(4, 4'h2);
      check("byte0", u_ctl.words[0] & 32'hFF, 32'h05);
      check("byte1", u_ctl.words[1] & 32'hFF, 32'h00);
      check("byte2", u_ctl.words[2] & 32'hF0, 32'h00);
      // token given up after one word when not kept
      apply(32'h0000_0269, 32'h3);
      pulse(7, 6);
      pulse(8, 6);
      left = 32'h800;
      drain(1, 4'h0);
      left = 32'h0;
      drain(1, 4'h0);
      check("next_chan", u_ctl.words[0] & 32'h1F80_0000, 32'h0800_0000);
      // short roll-over: reads two cycles apart step by 2 mod 16
      // run off first so the count restarts below the new roll-over
      wreg(tdcsm_pkg::ADDR_CTRL, 32'h0);
      wreg(tdcsm_pkg::ADDR_ROLL, 32'h0000_000F);
      wreg(tdcsm_pkg::ADDR_CTRL, 32'h3);
      rreg(tdcsm_pkg::ADDR_COARSE, w);
      for (int i = 0; i < 12; i++)
      begin
         rreg(tdcsm_pkg::ADDR_COARSE, v);
         check("coarse", v, (w + 32'h2) & 32'hF);
         w = v;
      end
      test_done();
   end
endmodule: tdcsm_top_tb_top
